// File: pkg/phy_mgmt_pkg.sv
`default_nettype none
package phy_mgmt_pkg;

  localparam int          REG_W     = 16;
  localparam int          NUM_REGS  = 32;
  localparam int          ADDR_W    = 5;

  localparam logic [4:0]  REG_PHY_CONTROL           = 5'h00;
  localparam logic [4:0]  REG_PHY_STATUS            = 5'h01;
  localparam logic [4:0]  REG_PHY_IDENTIFIER_HIGH   = 5'h02;
  localparam logic [4:0]  REG_PHY_IDENTIFIER_LOW    = 5'h03;
  localparam logic [4:0]  REG_AUTONEG_ADVERTISE     = 5'h04;
  localparam logic [4:0]  REG_LINK_PARTNER_ABILITY  = 5'h05;
  localparam logic [4:0]  REG_AUTONEG_EXPANSION     = 5'h06;
  localparam logic [4:0]  REG_NEXT_PAGE_TRANSMIT    = 5'h07;
  localparam logic [4:0]  REG_RESERVED_BLOCK_LOW    = 5'h08;
  localparam logic [4:0]  REG_PCS_CONTROL           = 5'h10;
  localparam logic [4:0]  REG_AUTONEG_READBACK_A    = 5'h11;
  localparam logic [4:0]  REG_AUTONEG_READBACK_B    = 5'h12;
  localparam logic [4:0]  REG_ANALOG_TEST           = 5'h13;
  localparam logic [4:0]  REG_USER_DEFINED          = 5'h14;
  localparam logic [4:0]  REG_RECEIVE_ERROR_COUNTER = 5'h15;
  localparam logic [4:0]  REG_ANALOG_TEST_GROUP     = 5'h16;
  localparam logic [4:0]  REG_ANALOG_TUNER_GROUP    = 5'h19;
  localparam logic [4:0]  REG_DEVICE_SPECIFIC_ONE   = 5'h1c;
  localparam logic [4:0]  REG_DEVICE_SPECIFIC_TWO   = 5'h1d;
  localparam logic [4:0]  REG_DEVICE_SPECIFIC_THREE = 5'h1e;
  localparam logic [4:0]  REG_QUICK_STATUS          = 5'h1f;
  localparam logic [4:0]  GROUP_LEN                 = 5'h03;

  // control register bit positions
  localparam int          CTL_SOFT_RESET   = 15;
  localparam int          CTL_LOOPBACK     = 14;
  localparam int          CTL_SPEED        = 13;
  localparam int          CTL_AN_ENABLE    = 12;
  localparam int          CTL_POWER_DOWN   = 11;
  localparam int          CTL_ISOLATE      = 10;
  localparam int          CTL_AN_RESTART   = 9;
  localparam int          CTL_DUPLEX       = 8;
  localparam int          CTL_COL_TEST     = 7;

  localparam logic [15:0] RST_PHY_CONTROL         = 16'h3000;
  localparam logic [15:0] RST_PHY_STATUS          = 16'h7849;
  localparam logic [15:0] RST_AUTONEG_ADVERTISE   = 16'h01e1;
  localparam logic [15:0] RST_DEVICE_SPECIFIC_TWO = 16'h2080;
  localparam logic [15:0] RST_ZERO                = 16'h0000;
  localparam logic [15:0] STATUS_AN_DONE_MASK     = 16'h0020;
  localparam logic [15:0] CTL_RESTART_MASK        = 16'h0200;

  localparam logic [15:0] MASK_CONTROL            = 16'hff80;
  localparam logic [15:0] MASK_ALL                = 16'hffff;
  localparam logic [15:0] MASK_NONE               = 16'h0000;

  // identifier values are arbitrary
  localparam logic [15:0] ID_HIGH_VALUE           = 16'h1234;
  localparam logic [15:0] ID_LOW_VALUE            = 16'h5670;
  localparam logic [4:0]  PHY_ADDR                = 5'h01;

  localparam logic [1:0]  OP_READ                 = 2'h2;
  localparam logic [1:0]  OP_WRITE                = 2'h1;
  localparam logic [3:0]  OP_LAST                 = 4'h1;
  localparam logic [3:0]  ADDR_LAST               = 4'h4;
  localparam logic [3:0]  DATA_LAST               = 4'hf;

  typedef enum logic [6:0] {
    S_IDLE  = 7'h01,
    S_START = 7'h02,
    S_OP    = 7'h04,
    S_PHYAD = 7'h08,
    S_REGAD = 7'h10,
    S_TA    = 7'h20,
    S_DATA  = 7'h40
  } mdio_state_e;

  function automatic logic in_group(input logic [4:0] addr, input logic [4:0] base);
    in_group = (addr >= base) && (addr < base + GROUP_LEN);
  endfunction : in_group

  // writable bits of each stored location; read-only ones store nothing
  function automatic logic [15:0] reg_mask(input logic [4:0] addr);
    if (addr == REG_PHY_CONTROL)
      reg_mask = MASK_CONTROL;
    else if (addr == REG_AUTONEG_ADVERTISE || addr == REG_NEXT_PAGE_TRANSMIT ||
             addr == REG_PCS_CONTROL || addr == REG_ANALOG_TEST ||
             addr == REG_USER_DEFINED || addr == REG_DEVICE_SPECIFIC_ONE ||
             addr == REG_DEVICE_SPECIFIC_TWO || addr == REG_DEVICE_SPECIFIC_THREE ||
             in_group(addr, REG_ANALOG_TEST_GROUP) || in_group(addr, REG_ANALOG_TUNER_GROUP))
      reg_mask = MASK_ALL;
    else
      reg_mask = MASK_NONE;
  endfunction : reg_mask

  function automatic logic [15:0] reg_reset(input logic [4:0] addr);
    if (addr == REG_PHY_CONTROL)
      reg_reset = RST_PHY_CONTROL;
    else if (addr == REG_AUTONEG_ADVERTISE)
      reg_reset = RST_AUTONEG_ADVERTISE;
    else if (addr == REG_DEVICE_SPECIFIC_TWO)
      reg_reset = RST_DEVICE_SPECIFIC_TWO;
    else
      reg_reset = RST_ZERO;
  endfunction : reg_reset

endpackage : phy_mgmt_pkg
`default_nettype wire

// File: logic/phy_mgmt_control_regs.sv
// Functional notes
// - thirty-two 16-bit registers, one per number
// - partner ability, expansion, next page reset zero
// - control bit 15 resets all, self-clears
// - loopback: no medium transmit, receive ignored
// - forced speed used only without autonegotiation
// - forced speed is bit ANDed with strap
// - bit 12 enables autonegotiation, resets one
// - power-down bit stops both transceivers
// - management still served while powered down
// - isolate bit only drives mii_isolate_o; collision output stays driven
// - autonegotiation starts by itself after reset
// - bit 9 restarts autonegotiation, resets zero
// - restart going high clears complete flag
// - restart bit self-clears once restarted
// - bit 8 duplex, ignored under autonegotiation
// - forced duplex is bit ORed with strap
// - collision test echoes transmit enable
// - control bits 6:0 read zero
// - complete flag set when done, cleared at start
`timescale 1ns/1ps
`default_nettype none
module phy_mgmt_control_regs (
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  input  wire logic clk_en_i,
  input  wire logic mdc_i,
  input  wire logic mdio_i,
  output var  logic mdio_o,
  output var  logic mdio_oe_o,
  input  wire logic speed_strap_i,
  input  wire logic duplex_strap_input,
  input  wire logic mii_transmit_enable_in,
  input  wire logic an_started_i,
  input  wire logic an_done_i,
  input  wire logic an_speed_100_i,
  input  wire logic an_full_duplex_i,
  output var  logic an_restart_o,
  output var  logic autoneg_enable_o,
  output var  logic speed_100_o,
  output var  logic full_duplex_o,
  output var  logic loopback_o,
  output var  logic medium_tx_en_o,
  output var  logic power_down_o,
  output var  logic mii_isolate_o,
  output var  logic mii_collision_out
);
  import phy_mgmt_pkg::*;

  localparam int SYNC_W = 4;

  logic [SYNC_W-1:0] pin_raw;
  logic [SYNC_W-1:0] pin_s1, pin_s2;
  logic              mdc_s3;
  wire  logic        mdc_s, mdio_s, speed_strap_s, duplex_strap_s, mdc_rise;

  logic [15:0]       regs       [NUM_REGS];
  logic [15:0]       next_regs  [NUM_REGS];
  logic [15:0]       rd_vec     [NUM_REGS];
  logic              wr_en;
  logic [4:0]        wr_addr;
  logic [15:0]       wr_data;
  logic              an_complete;
  logic              boot_pending;

  mdio_state_e       state, next_state;
  logic [3:0]        bit_cnt, next_bit_cnt;
  logic [1:0]        op, next_op;
  logic [4:0]        phyad, next_phyad;
  logic [4:0]        regad, next_regad;
  logic [15:0]       shreg, next_shreg;
  logic              rd_active, next_rd_active;
  logic              next_mdio_o, next_mdio_oe, frame_wr;

  // pins cross into the clock domain through two flops
  assign pin_raw = {mdc_i, mdio_i, speed_strap_i, duplex_strap_input};

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      mdc_s3 <= 1'b0;
    end
    else if (clk_en_i)
    begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      mdc_s3 <= pin_s2[3];
    end
  end

  assign mdc_s          = pin_s2[3];
  assign mdio_s         = pin_s2[2];
  assign speed_strap_s  = pin_s2[1];
  assign duplex_strap_s = pin_s2[0];
  assign mdc_rise       = mdc_s & ~mdc_s3;

  wire logic [15:0] ctl          = regs[REG_PHY_CONTROL];
  wire logic        soft_reset   = ctl[CTL_SOFT_RESET];
  wire logic        wr_ctl       = wr_en && (wr_addr == REG_PHY_CONTROL);
  wire logic        wr_restart   = wr_ctl && wr_data[CTL_AN_RESTART] && !ctl[CTL_AN_RESTART];
  wire logic [15:0] status_word  = RST_PHY_STATUS | (an_complete ? STATUS_AN_DONE_MASK : RST_ZERO);
  wire logic        forced_speed = ctl[CTL_SPEED] & speed_strap_s;
  wire logic        forced_dup   = ctl[CTL_DUPLEX] | duplex_strap_s;

  // register array: soft reset first, then management write, then restart clear
  genvar gi;
  generate
    for (gi = 0; gi < NUM_REGS; gi++)
    begin : g_reg
      localparam logic [4:0] IDX = 5'(gi);
      wire logic wr_hit = wr_en && (wr_addr == IDX);

      assign next_regs[gi] =
          soft_reset ? reg_reset(IDX) :
          wr_hit ? ((wr_data & reg_mask(IDX)) | (regs[gi] & ~reg_mask(IDX))) :
          (IDX == REG_PHY_CONTROL && an_started_i) ? (regs[gi] & ~CTL_RESTART_MASK) :
          regs[gi];

      assign rd_vec[gi] =
          (IDX == REG_PHY_STATUS)          ? status_word :
          (IDX == REG_PHY_IDENTIFIER_HIGH) ? ID_HIGH_VALUE :
          (IDX == REG_PHY_IDENTIFIER_LOW)  ? ID_LOW_VALUE :
          regs[gi];

      always_ff @(posedge clk_i or negedge rst_b_i)
      begin
        if (!rst_b_i)
          regs[gi] <= reg_reset(IDX);
        else if (clk_en_i)
          regs[gi] <= next_regs[gi];
      end
    end
  endgenerate

  // hardware set wins over the clear
  wire logic next_an_complete = an_done_i ? 1'b1 :
      (wr_restart || an_started_i || soft_reset) ? 1'b0 : an_complete;
  wire logic next_boot = soft_reset ? 1'b1 : an_started_i ? 1'b0 : boot_pending;

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      an_complete  <= 1'b0;
      boot_pending <= 1'b1;
    end
    else if (clk_en_i)
    begin
      an_complete  <= next_an_complete;
      boot_pending <= next_boot;
    end
  end

  wire logic next_an_restart = ctl[CTL_AN_ENABLE] & (ctl[CTL_AN_RESTART] | boot_pending);
  wire logic next_speed      = ctl[CTL_AN_ENABLE] ? an_speed_100_i : forced_speed;
  wire logic next_duplex     = ctl[CTL_AN_ENABLE] ? an_full_duplex_i : forced_dup;
  wire logic next_medium_tx  = mii_transmit_enable_in & ~ctl[CTL_LOOPBACK]
                               & ~ctl[CTL_POWER_DOWN];
  wire logic next_collision  = ctl[CTL_COL_TEST] & mii_transmit_enable_in;

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      an_restart_o      <= 1'b0;
      autoneg_enable_o  <= 1'b0;
      speed_100_o       <= 1'b0;
      full_duplex_o     <= 1'b0;
      loopback_o        <= 1'b0;
      medium_tx_en_o    <= 1'b0;
      power_down_o      <= 1'b0;
      mii_isolate_o     <= 1'b0;
      mii_collision_out <= 1'b0;
    end
    else if (clk_en_i)
    begin
      an_restart_o      <= next_an_restart;
      autoneg_enable_o  <= ctl[CTL_AN_ENABLE];
      speed_100_o       <= next_speed;
      full_duplex_o     <= next_duplex;
      loopback_o        <= ctl[CTL_LOOPBACK];
      medium_tx_en_o    <= next_medium_tx;
      power_down_o      <= ctl[CTL_POWER_DOWN];
      mii_isolate_o     <= ctl[CTL_ISOLATE];
      mii_collision_out <= next_collision;
    end
  end

  // management frame engine; power-down does not gate it
  always_comb
  begin
    next_state     = state;
    next_bit_cnt   = bit_cnt;
    next_op        = op;
    next_phyad     = phyad;
    next_regad     = regad;
    next_shreg     = shreg;
    next_rd_active = rd_active;
    next_mdio_o    = mdio_o;
    next_mdio_oe   = mdio_oe_o;
    frame_wr       = 1'b0;
    if (mdc_rise)
    begin
      unique case (state)
        S_IDLE:
          if (!mdio_s)
            next_state = S_START;
        S_START:
        begin
          next_state   = mdio_s ? S_OP : S_IDLE;
          next_bit_cnt = '0;
        end
        S_OP:
        begin
          next_op = {op[0], mdio_s};
          if (bit_cnt == OP_LAST)
          begin
            next_bit_cnt = '0;
            next_state   = ({op[0], mdio_s} == OP_READ || {op[0], mdio_s} == OP_WRITE)
                           ? S_PHYAD : S_IDLE;
          end
          else
            next_bit_cnt = bit_cnt + 4'h1;
        end
        S_PHYAD:
        begin
          next_phyad = {phyad[3:0], mdio_s};
          if (bit_cnt == ADDR_LAST)
          begin
            next_bit_cnt = '0;
            next_state   = S_REGAD;
          end
          else
            next_bit_cnt = bit_cnt + 4'h1;
        end
        S_REGAD:
        begin
          next_regad = {regad[3:0], mdio_s};
          if (bit_cnt == ADDR_LAST)
          begin
            next_bit_cnt   = '0;
            next_state     = S_TA;
            next_rd_active = (op == OP_READ) && (phyad == PHY_ADDR);
            next_shreg     = rd_vec[{regad[3:0], mdio_s}];
          end
          else
            next_bit_cnt = bit_cnt + 4'h1;
        end
        S_TA:
          if (bit_cnt == '0)
          begin
            next_bit_cnt = 4'h1;
            next_mdio_oe = rd_active;
            next_mdio_o  = 1'b0;
          end
          else
          begin
            next_bit_cnt = '0;
            next_state   = S_DATA;
            if (rd_active)
            begin
              next_mdio_o = shreg[15];
              next_shreg  = {shreg[14:0], 1'b0};
            end
          end
        S_DATA:
        begin
          if (!rd_active)
            next_shreg = {shreg[14:0], mdio_s};
          if (bit_cnt == DATA_LAST)
          begin
            next_state     = S_IDLE;
            next_mdio_oe   = 1'b0;
            next_mdio_o    = 1'b0;
            next_rd_active = 1'b0;
            frame_wr       = !rd_active && (phyad == PHY_ADDR);
          end
          else
          begin
            next_bit_cnt = bit_cnt + 4'h1;
            if (rd_active)
            begin
              next_mdio_o = shreg[15];
              next_shreg  = {shreg[14:0], 1'b0};
            end
          end
        end
        default:
        begin
          next_state     = S_IDLE;
          next_mdio_oe   = 1'b0;
          next_rd_active = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state     <= S_IDLE;
      bit_cnt   <= '0;
      op        <= '0;
      phyad     <= '0;
      regad     <= '0;
      shreg     <= '0;
      rd_active <= 1'b0;
      mdio_o    <= 1'b0;
      mdio_oe_o <= 1'b0;
    end
    else if (clk_en_i)
    begin
      state     <= next_state;
      bit_cnt   <= next_bit_cnt;
      op        <= next_op;
      phyad     <= next_phyad;
      regad     <= next_regad;
      shreg     <= next_shreg;
      rd_active <= next_rd_active;
      mdio_o    <= next_mdio_o;
      mdio_oe_o <= next_mdio_oe;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      wr_en   <= 1'b0;
      wr_addr <= '0;
      wr_data <= '0;
    end
    else if (clk_en_i)
    begin
      wr_en   <= frame_wr;
      wr_addr <= regad;
      wr_data <= next_shreg;
    end
  end

  sequence s_soft_req;
    clk_en_i && soft_reset && !an_done_i;
  endsequence
  sequence s_restart_req;
    clk_en_i && wr_restart && !an_done_i;
  endsequence

  AST_SOFT_RESET: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    s_soft_req |=> (regs[0] == RST_PHY_CONTROL) && !an_complete
                   && (regs[REG_NEXT_PAGE_TRANSMIT] == RST_ZERO))
    else $error("soft reset did not restore defaults");
  AST_RESTART_CLEARS: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    s_restart_req |=> !an_complete)
    else $error("restart did not clear complete flag");
  AST_RESTART_SELF_CLEAR: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (clk_en_i && an_started_i && !wr_ctl && !soft_reset) |=> !ctl[CTL_AN_RESTART])
    else $error("restart bit not cleared after start");
  AST_LOOPBACK_SILENT: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    loopback_o |-> !medium_tx_en_o)
    else $error("medium transmit during loopback");
  AST_FORCED_SPEED: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (clk_en_i && !ctl[CTL_AN_ENABLE])
      |=> speed_100_o == ($past(ctl[CTL_SPEED]) & $past(speed_strap_s)))
    else $error("forced speed not bit AND strap");
  AST_FORCED_DUPLEX: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (clk_en_i && !ctl[CTL_AN_ENABLE])
      |=> full_duplex_o == ($past(ctl[CTL_DUPLEX]) | $past(duplex_strap_s)))
    else $error("forced duplex not bit OR strap");
  AST_COLLISION_TEST: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (clk_en_i && ctl[CTL_COL_TEST] && mii_transmit_enable_in) |=> mii_collision_out)
    else $error("collision test did not echo transmit enable");
  AST_ISOLATE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    clk_en_i |=> mii_isolate_o == $past(ctl[CTL_ISOLATE]))
    else $error("isolate output does not follow control");
  AST_RESERVED_ZERO: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    rd_vec[0][CTL_COL_TEST-1:0] == '0)
    else $error("reserved control bits not zero");
  AST_WRITE_IN_POWER_DOWN: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (clk_en_i && ctl[CTL_POWER_DOWN] && wr_en && wr_addr == REG_AUTONEG_ADVERTISE && !soft_reset)
      |=> regs[REG_AUTONEG_ADVERTISE] == $past(wr_data))
    else $error("write lost while powered down");
  AST_STATUS_READ_ONLY: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (clk_en_i && wr_en && wr_addr == REG_LINK_PARTNER_ABILITY) |=> rd_vec[REG_LINK_PARTNER_ABILITY] == RST_ZERO)
    else $error("read-only register changed by write");
endmodule : phy_mgmt_control_regs
`default_nettype wire

// File: tb/mdio_station.sv
`timescale 1ns/1ps
`default_nettype none
module mdio_station (
  input  wire logic clk_i,
  input  wire logic mdio_line_i,
  output var  logic mdc_o,
  output var  logic mdio_o,
  output var  logic mdio_oe_o
);
  import phy_mgmt_pkg::*;

  // management clock rests low between frames
  initial
  begin
    mdc_o = 1'b0;
    mdio_o = 1'b1;
    mdio_oe_o = 1'b0;
  end

  // drive in the low phase, sample the line at the rising edge
  task automatic bit_io(input logic b, input logic drv, output logic s);
    @(posedge clk_i);
    #1;
    mdio_o = b;
    mdio_oe_o = drv;
    repeat (6) @(posedge clk_i);
    #1;
    mdc_o = 1'b1;
    s = mdio_line_i;
    repeat (6) @(posedge clk_i);
    #1;
    mdc_o = 1'b0;
  endtask : bit_io

  // one frame by register number; reads release the line from the turnaround on
  task automatic mgmt(input logic wr, input logic [4:0] pa, input logic [4:0] ra,
                      input logic [15:0] wd, output logic [15:0] rd);
    logic [31:0] f;
    logic        s;
    f = {2'b01, (wr ? OP_WRITE : OP_READ), pa, ra, 2'b10, wd};
    rd = 16'h0000;
    bit_io(1'b1, 1'b1, s);
    for (int i = 31; i >= 0; i--)
    begin
      bit_io(f[i], wr || i > 17, s);
      rd = {rd[14:0], s};
    end
    mdio_oe_o = 1'b0;
    repeat (4) @(posedge clk_i);
    #1;
  endtask : mgmt
endmodule : mdio_station
`default_nettype wire

// File: tb/tb_phy_mgmt_control_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_phy_mgmt_control_regs;
  import phy_mgmt_pkg::*;

  logic        clk = 1'b0;
  logic        clk_en = 1'b1;
  logic        rst_b = 1'b0;
  logic        spd_strap = 1'b0;
  logic        dup_strap = 1'b0;
  logic        tx_en = 1'b0;
  logic        an_started = 1'b0;
  logic        an_done = 1'b0;
  logic        an_spd = 1'b0;
  logic        an_fdx = 1'b0;
  logic [15:0] r;
  int          error_cnt = 0;
  int          comparisons = 0;
  wire logic   mdc, mdio_line, phy_d, phy_oe, sta_d, sta_oe;
  wire logic   an_restart, an_en, spd100, fdx, lpbk, med_tx, power_down_bit, iso, col;
  wire logic [7:0] outs = {lpbk, power_down_bit, iso, an_en, spd100, fdx, med_tx, col};

  localparam logic [4:0]  DEF_A [15] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06,
    5'h07, 5'h08, 5'h10, 5'h11, 5'h15, 5'h1d, 5'h1e, 5'h1f};
  localparam logic [15:0] DEF_V [15] = '{16'h3000, 16'h7849, ID_HIGH_VALUE, ID_LOW_VALUE,
    16'h01e1, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h2080, 16'h0000, 16'h0000};
  localparam logic [4:0]  WR_A [8] = '{5'h04, 5'h07, 5'h10, 5'h1d, 5'h01, 5'h05, 5'h08, 5'h1f};
  localparam logic [15:0] WR_V [8] = '{16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'h7849,
    16'h0000, 16'h0000, 16'h0000};

  always #5 clk = ~clk;

  // pull-up on the management data line
  assign mdio_line = phy_oe ? phy_d : (sta_oe ? sta_d : 1'b1);

  phy_mgmt_control_regs i_phy_mgmt_control_regs (
    .clk_i                  (clk),
    .rst_b_i                (rst_b),
    .clk_en_i               (clk_en),
    .mdc_i                  (mdc),
    .mdio_i                 (mdio_line),
    .mdio_o                 (phy_d),
    .mdio_oe_o              (phy_oe),
    .speed_strap_i          (spd_strap),
    .duplex_strap_input     (dup_strap),
    .mii_transmit_enable_in (tx_en),
    .an_started_i           (an_started),
    .an_done_i              (an_done),
    .an_speed_100_i         (an_spd),
    .an_full_duplex_i       (an_fdx),
    .an_restart_o           (an_restart),
    .autoneg_enable_o       (an_en),
    .speed_100_o            (spd100),
    .full_duplex_o          (fdx),
    .loopback_o             (lpbk),
    .medium_tx_en_o         (med_tx),
    .power_down_o           (power_down_bit),
    .mii_isolate_o          (iso),
    .mii_collision_out      (col)
  );

  mdio_station i_mdio_station (
    .clk_i       (clk),
    .mdio_line_i (mdio_line),
    .mdc_o       (mdc),
    .mdio_o      (sta_d),
    .mdio_oe_o   (sta_oe)
  );

  task automatic final_report();
    if (error_cnt == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      $display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
      error_cnt++;
    end
  endtask : chk

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    logic [15:0] q;
    i_mdio_station.mgmt(1'b1, PHY_ADDR, a, d, q);
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    logic [15:0] q;
    i_mdio_station.mgmt(1'b0, PHY_ADDR, a, 16'h0000, q);
    chk(q, e);
  endtask : rd

  task automatic defaults();
    for (int k = 0; k < 15; k++)
      rd(DEF_A[k], DEF_V[k]);
  endtask : defaults

  initial
  begin
    repeat (90000) @(posedge clk);
    error_cnt++;
    final_report();
  end

  initial
  begin
    tick(4);
    rst_b = 1'b1;
    tick(2);
    chk({15'h0000, an_en}, 16'h0001);
    chk({15'h0000, an_restart}, 16'h0001);
    an_started = 1'b1;
    tick(1);
    an_started = 1'b0;
    tick(2);
    chk({15'h0000, an_restart}, 16'h0000);
    defaults();
    // write all eight places first, then read back, so aliasing shows up
    for (int k = 0; k < 8; k++)
      wr(WR_A[k], 16'hffff);
    for (int k = 0; k < 8; k++)
      rd(WR_A[k], WR_V[k]);
    i_mdio_station.mgmt(1'b1, 5'h02, 5'h04, 16'h0000, r);
    i_mdio_station.mgmt(1'b0, 5'h02, 5'h04, 16'h0000, r);
    chk(r, 16'hffff);
    rd(5'h04, 16'hffff);
    wr(5'h00, 16'h6dff);
    rd(5'h00, 16'h6d80);
    wr(5'h04, 16'h5a5a);
    rd(5'h04, 16'h5a5a);
    tx_en = 1'b1;
    tick(3);
    chk({8'h00, outs}, 16'h00e5);
    spd_strap = 1'b1;
    tick(5);
    chk({8'h00, outs}, 16'h00ed);
    wr(5'h00, 16'h0080);
    chk({8'h00, outs}, 16'h0003);
    dup_strap = 1'b1;
    tx_en = 1'b0;
    tick(5);
    chk({8'h00, outs}, 16'h0004);
    // clock enable low must freeze every output
    clk_en = 1'b0;
    tx_en = 1'b1;
    tick(4);
    chk({8'h00, outs}, 16'h0004);
    clk_en = 1'b1;
    tick(2);
    chk({8'h00, outs}, 16'h0007);
    tx_en = 1'b0;
    wr(5'h00, 16'h3100);
    chk({8'h00, outs}, 16'h0010);
    an_done = 1'b1;
    tick(1);
    an_done = 1'b0;
    rd(5'h01, 16'h7869);
    wr(5'h00, 16'h1200);
    rd(5'h01, 16'h7849);
    chk({15'h0000, an_restart}, 16'h0001);
    rd(5'h00, 16'h1200);
    an_started = 1'b1;
    tick(1);
    an_started = 1'b0;
    rd(5'h00, 16'h1000);
    chk({15'h0000, an_restart}, 16'h0000);
    an_done = 1'b1;
    tick(1);
    an_done = 1'b0;
    wr(5'h00, 16'h8000);
    defaults();
    chk({15'h0000, an_restart}, 16'h0001);
    final_report();
  end
endmodule : tb_phy_mgmt_control_regs
`default_nettype wire
